/* File: src/lbta_core.sv */
// Transfer attribute driver and sampler for the local bus port.
`timescale 1ns/1ps
module lbta_core
  import lbta_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  // Master side request from the internal channel.
  input  wire logic              mst_start,
  input  wire logic              mst_own,
  input  wire logic [ADDR_W-1:0] mst_addr,
  input  wire logic              mst_read,
  input  wire logic [1:0]        mst_size,
  input  wire logic [TC_W-1:0]   image_tc,
  // Pins.
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_oe_n,
  output logic [TC_W-1:0]        transfer_code_o,
  output logic                   transfer_code_oe_n,
  output logic                   transfer_start_n_o,
  output logic                   transfer_start_n_oe_n,
  output logic [1:0]             transfer_size_o,
  output logic                   transfer_size_oe_n,
  output logic                   rw_o,
  output logic                   rw_oe_n,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [TC_W-1:0]   transfer_code_i,
  input  wire logic              transfer_start_n_i,
  input  wire logic [1:0]        transfer_size_i,
  input  wire logic              rw_i,
  // Slave side results, then the master's lane enables.
  output logic                   slv_start,
  output logic [TC_W-1:0]        slv_tc,
  output logic [1:0]             slv_size,
  output logic                   slv_burst,
  output logic                   slv_read,
  output logic [3:0]             slv_lanes,
  output logic [3:0]             mst_lanes
);

  // ****************************************
  // Decoding
  // ****************************************
  // Size code 11 is a line burst on the slave side and reserved on the master side.
  function automatic logic is_line
  (
    input logic [1:0] size
  );
    return (size == SIZ_LINE);
  endfunction

  // ****************************************
  // Master drive
  // ****************************************
  logic [ADDR_W-1:0] addr_q;
  logic [TC_W-1:0]   tc_q;
  logic [1:0]        siz_q;
  logic              rw_q;
  logic              ts_q;
  logic              own_q;
  wire  logic [1:0]  siz_safe;
  wire  logic        mst_take;

  // A reserved request is forced to a word access rather than leaking 11 onto the bus.
  assign siz_safe = is_line(mst_size) ? SIZ_WORD : mst_size;
  // A start that arrives while the strobe is still low is dropped, so two
  // transfers never merge into one long strobe; the channel must wait a cycle.
  assign mst_take = mst_start && mst_own && !ts_q;

  // Address and attributes share one register stage, which keeps them aligned on the pins.
  // Direction resets to read, the harmless level if a pin is sampled before the first start.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q <= '0;
      tc_q   <= TC_RST;
      siz_q  <= SIZ_RST;
      rw_q   <= 1'b1;
      ts_q   <= 1'b0;
      own_q  <= 1'b0;
    end
    else
    begin
      own_q <= mst_own;
      ts_q  <= mst_take;
      if (mst_take)
      begin
        addr_q <= mst_addr;
        tc_q   <= image_tc;
        siz_q  <= siz_safe;
        rw_q   <= mst_read;
      end
    end
  end

  assign addr_o                = addr_q;
  assign transfer_code_o       = tc_q;
  assign transfer_size_o       = siz_q;
  assign rw_o                  = rw_q;
  assign transfer_start_n_o    = !ts_q;
  assign addr_oe_n             = !own_q;
  assign transfer_code_oe_n    = !own_q;
  assign transfer_size_oe_n    = !own_q;
  assign transfer_start_n_oe_n = !own_q;
  assign rw_oe_n               = !own_q;

  lbta_lanes u_mlanes
  (
    .size    (siz_q),
    .addr_lo (addr_q[1:0]),
    .lanes   (mst_lanes)
  );

  // ****************************************
  // Slave capture
  // ****************************************
  wire logic       ts_seen;
  wire logic       slv_line;
  wire logic [3:0] lanes_d;
  assign ts_seen = !transfer_start_n_i && !own_q;
  // Port width is not modelled: lanes always assume a full 32-bit port.
  assign slv_line = is_line(transfer_size_i);
  // Captured attributes hold until the next start, so the consumer may read them late.

  lbta_lanes u_slanes
  (
    .size    (transfer_size_i),
    .addr_lo (addr_i[1:0]),
    .lanes   (lanes_d)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slv_start <= 1'b0;
      slv_tc    <= TC_RST;
      slv_size  <= SIZ_RST;
      slv_burst <= 1'b0;
      slv_read  <= 1'b1;
      slv_lanes <= '0;
    end
    else
    begin
      slv_start <= ts_seen;
      if (ts_seen)
      begin
        slv_tc    <= transfer_code_i;
        slv_size  <= transfer_size_i;
        slv_burst <= slv_line;
        slv_read  <= rw_i;
        slv_lanes <= slv_line ? LANES_ALL : lanes_d;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Properties triggered by a request or start look one edge past it because every attribute output is registered.
  a_start_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    !transfer_start_n_o |=> transfer_start_n_o)
    else $error("start strobe longer than one cycle");

  a_start_needs_take: assert property (@(posedge clk) disable iff (!nrst)
    !mst_take |=> transfer_start_n_o)
    else $error("start strobe without an accepted request");

  a_no_reserved_size: assert property (@(posedge clk) disable iff (!nrst)
    !transfer_size_oe_n |-> transfer_size_o != SIZ_LINE)
    else $error("master drove reserved size");

  a_tc_from_image: assert property (@(posedge clk) disable iff (!nrst)
    mst_take |=> transfer_code_o == $past(image_tc))
    else $error("transfer code differs from image");

  a_tc_with_addr: assert property (@(posedge clk) disable iff (!nrst)
    $changed(transfer_code_o) |-> $past(mst_take))
    else $error("transfer code moved without an address cycle");

  a_attr_hold: assert property (@(posedge clk) disable iff (!nrst)
    !mst_take |=> $stable(transfer_code_o) && $stable(transfer_size_o) &&
                  $stable(addr_o) && $stable(rw_o))
    else $error("attributes moved without an accepted request");

  a_slave_capture: assert property (@(posedge clk) disable iff (!nrst)
    ts_seen |=> slv_start && slv_tc == $past(transfer_code_i))
    else $error("slave transfer code not captured");

  a_slave_attrs: assert property (@(posedge clk) disable iff (!nrst)
    ts_seen |=> slv_size == $past(transfer_size_i) && slv_read == $past(rw_i))
    else $error("slave size or direction not captured");

  a_slave_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (!transfer_start_n_i && own_q) |=> !slv_start)
    else $error("own start strobe captured as slave");

  a_line_burst: assert property (@(posedge clk) disable iff (!nrst)
    (ts_seen && transfer_size_i == SIZ_LINE) |=> slv_burst && slv_lanes == LANES_ALL)
    else $error("line size not taken as burst");

  a_slave_lanes: assert property (@(posedge clk) disable iff (!nrst)
    (ts_seen && transfer_size_i == SIZ_BYTE) |=> $onehot(slv_lanes))
    else $error("slave byte access must enable one lane");

  a_float_unowned: assert property (@(posedge clk) disable iff (!nrst)
    !mst_own |=> transfer_code_oe_n && transfer_size_oe_n && transfer_start_n_oe_n)
    else $error("attribute pins driven without ownership");

  a_drive_owned: assert property (@(posedge clk) disable iff (!nrst)
    mst_own |=> !transfer_code_oe_n && !transfer_size_oe_n && !transfer_start_n_oe_n)
    else $error("attribute pins floating while owned");

  a_rw_timing: assert property (@(posedge clk) disable iff (!nrst)
    mst_take |=> rw_o == $past(mst_read) && addr_o == $past(mst_addr))
    else $error("direction not timed with address");

  a_byte_lanes: assert property (@(posedge clk) disable iff (!nrst)
    transfer_size_o == SIZ_BYTE |-> $onehot(mst_lanes))
    else $error("byte access must enable one lane");
endmodule

/* File: src/lbta_lanes.sv */
// Byte lane decoder for size code and low address bits.
`timescale 1ns/1ps
module lbta_lanes
  import lbta_pkg::*;
(
  input  wire logic [1:0] size,
  input  wire logic [1:0] addr_lo,
  output logic      [3:0] lanes
);
  // Lane 3 is the byte at address offset 0, big endian like the processor bus.
  wire logic [3:0] lanes_byte;
  wire logic [3:0] lanes_half;
  assign lanes_byte = 4'(LANES_B0 << (2'h3 - addr_lo));
  assign lanes_half = addr_lo[1] ? LANES_LO2 : 4'(LANES_LO2 << 2);
  assign lanes = (size == SIZ_BYTE) ? lanes_byte :
                 (size == SIZ_HALF) ? lanes_half : LANES_ALL;
endmodule

/* File: src/lbta_pkg.sv */
// Package of constants for the local bus transfer attribute block.
package lbta_pkg;
  localparam int          TC_W      = 4;
  localparam int          ADDR_W    = 32;
  localparam logic [1:0]  SIZ_WORD  = 2'h0;
  localparam logic [1:0]  SIZ_BYTE  = 2'h1;
  localparam logic [1:0]  SIZ_HALF  = 2'h2;
  localparam logic [1:0]  SIZ_LINE  = 2'h3;
  localparam logic [3:0]  LANES_ALL = 4'hf;
  localparam logic [3:0]  LANES_LO2 = 4'h3;
  localparam logic [3:0]  LANES_B0  = 4'h1;
  localparam logic [3:0]  TC_RST    = 4'h0;
  localparam logic [1:0]  SIZ_RST   = 2'h0;
endpackage

/* File: tb/lbta_agent.sv */
// Far side bus agent model that starts transfers toward the device.
`timescale 1ns/1ps
module lbta_agent
  import lbta_pkg::*;
(
  input  wire logic         clk,
  output logic [ADDR_W-1:0] addr,
  output logic [TC_W-1:0]   tc,
  output logic              ts_n,
  output logic [1:0]        size,
  output logic              rw
);
  initial
  begin
    {addr, tc, size, rw} = '0;
    ts_n = 1'h1;
  end
  // Released lines show the inverse so a stale value cannot pass as valid.
  task go(input logic [TC_W-1:0] c, input logic [1:0] s, input logic r,
          input logic [ADDR_W-1:0] a);
    @(posedge clk);
    #1;
    {addr, tc, size, rw, ts_n} = {a, c, s, r, 1'h0};
    @(posedge clk);
    #1;
    {addr, tc, size, rw, ts_n} = {~a, ~c, ~s, ~r, 1'h1};
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the local bus transfer attribute block.
`timescale 1ns/1ps
module tb
  import lbta_pkg::*;
;
  logic              clk, nrst, own, st, rd, t_o, t_w, t_ag, r_o, r_w, r_ag;
  logic [ADDR_W-1:0] ma, a_o, a_w, a_ag;
  logic [TC_W-1:0]   tc, c_o, c_w, c_ag, s_tc;
  logic [1:0]        sz, z_o, z_w, z_ag, s_sz;
  logic [4:0]        oe_n;
  logic              s_st, s_bu, s_rd;
  logic [3:0]        s_ln, m_ln;
  int                error_cnt, num_checks, cyc;
  assign a_w = oe_n[4] ? a_ag : a_o;
  assign c_w = oe_n[3] ? c_ag : c_o;
  assign t_w = oe_n[2] ? t_ag : t_o;
  assign z_w = oe_n[1] ? z_ag : z_o;
  assign r_w = oe_n[0] ? r_ag : r_o;
  lbta_core u_dut (.clk(clk), .nrst(nrst), .mst_start(st), .mst_own(own),
    .mst_addr(ma), .mst_read(rd), .mst_size(sz), .image_tc(tc), .addr_o(a_o),
    .addr_oe_n(oe_n[4]), .transfer_code_o(c_o), .transfer_code_oe_n(oe_n[3]),
    .transfer_start_n_o(t_o), .transfer_start_n_oe_n(oe_n[2]),
    .transfer_size_o(z_o), .transfer_size_oe_n(oe_n[1]), .rw_o(r_o),
    .rw_oe_n(oe_n[0]), .addr_i(a_w), .transfer_code_i(c_w),
    .transfer_start_n_i(t_w), .transfer_size_i(z_w), .rw_i(r_w),
    .slv_start(s_st), .slv_tc(s_tc), .slv_size(s_sz), .slv_burst(s_bu),
    .slv_read(s_rd), .slv_lanes(s_ln), .mst_lanes(m_ln));
  lbta_agent u_agent (.clk(clk), .addr(a_ag), .tc(c_ag), .ts_n(t_ag), .size(z_ag),
    .rw(r_ag));
  function automatic logic [3:0] lanes_f(input logic [1:0] s, input logic [1:0] a);
    return (s == SIZ_BYTE) ? 4'h8 >> a : (s == SIZ_HALF) ? (a[1] ? 4'h3 : 4'hc) : 4'hf;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task master(input logic [1:0] s, input logic [1:0] lo);
    @(posedge clk);
    #1;
    {st, sz, ma, tc, rd} = {1'h1, s, 30'h2345678, lo, 2'h1, s, lo[0]};
    @(posedge clk);
    #1;
    st = 1'h0;
    chk(t_o, 0);
    chk(a_o, ma);
    chk(c_o, tc);
    chk(z_o, (s == SIZ_LINE) ? SIZ_WORD : s);
    chk(r_o, rd);
    chk(m_ln, lanes_f((s == SIZ_LINE) ? SIZ_WORD : s, lo));
    chk(oe_n, 5'h00);
    @(posedge clk);
    #1;
    chk(t_o, 1);
  endtask
  task slave(input logic [1:0] s, input logic [1:0] lo);
    u_agent.go({lo, s}, s, lo[1], {30'h1abcdef, lo});
    chk(s_st, 1);
    chk({s_tc, s_sz, s_rd}, {lo, s, s, lo[1]});
    chk(s_bu, s == SIZ_LINE);
    chk(s_ln, lanes_f(s, lo));
    @(posedge clk);
    #1;
    chk(s_st, 0);
  endtask
  task rst_mid;
    nrst = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(oe_n, 5'h1f);
    chk(t_o, 1'h1);
    chk(c_o, TC_RST);
    chk(z_o, SIZ_RST);
    chk(r_o, 1'h1);
    chk({s_st, s_rd}, 2'h1);
    chk(m_ln, LANES_ALL);
    nrst = 1'h1;
  endtask
  task back2back;
    @(posedge clk);
    #1;
    {st, sz, ma, tc, rd} = {1'h1, SIZ_HALF, 32'h00000012, 4'h9, 1'h1};
    @(posedge clk);
    #1;
    {sz, ma, tc, rd} = {SIZ_BYTE, 32'h00000033, 4'h2, 1'h0};
    chk(t_o, 1'h0);
    @(posedge clk);
    #1;
    st = 1'h0;
    chk(t_o, 1'h1);
    chk(a_o, 32'h00000012);
    chk(c_o, 4'h9);
    chk(z_o, SIZ_HALF);
    chk(r_o, 1'h1);
    chk(m_ln, lanes_f(SIZ_HALF, 2'h2));
  endtask
  task refuse;
    own = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(oe_n, 5'h1f);
    st = 1'h1;
    @(posedge clk);
    #1;
    st = 1'h0;
    chk(t_o, 1'h1);
    @(posedge clk);
    #1;
    chk(s_st, 0);
  endtask
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    {nrst, own, st, rd, ma, tc, sz} = '0;
    repeat (12) @(posedge clk);
    #1;
    {nrst, own} = 2'h3;
    for (int i = 0; i < 16; i++)
      master(i[3:2], i[1:0]);
    rst_mid;
    back2back;
    refuse;
    for (int i = 0; i < 16; i++)
      slave(i[3:2], i[1:0]);
    close_out;
  end
endmodule
